// ==== pps_defines.vh ====
// Purpose: constants for the peripheral input pin select block
// Assumes: apb word offsets, 16-bit selector registers
// Notes: definitions only
`ifndef PPS_DEFINES_VH
`define PPS_DEFINES_VH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define PPS_OFF_TMR_CLK     12'h000
`define PPS_OFF_CAP_12      12'h004
`define PPS_OFF_CAP_3       12'h008
`define PPS_OFF_CMP_FLT     12'h00c
`define PPS_OFF_SER         12'h010
`define PPS_OFF_SPI         12'h014
`define PPS_OFF_LOCK        12'h018

// ----------------------------------------
// field layout
// ----------------------------------------
`define PPS_SEL_W           5
`define PPS_LO_LSB          0
`define PPS_HI_LSB          8
`define PPS_SEL_RESET       5'h1f
`define PPS_SEL_GROUND      5'h1f
`define PPS_SEL_MAX_PIN     5'h19
`define PPS_NUM_PINS        26
`define PPS_NUM_SEL         10

`endif

// ==== pps_sync3.v ====
// Purpose: three-stage synchroniser for pin levels
// Assumes: asynchronous pins, single clock
// Notes: output valid once stages two and three agree
`timescale 1ns/1ps

module pps_sync3 #(
    parameter WIDTH = 26
) (
    // clock and reset
    input  wire             pclk,
    input  wire             presetn,
    input  wire             clk_en,
    // pins
    input  wire [WIDTH-1:0] pin_async,
    output reg  [WIDTH-1:0] pin_sync_q
);

    reg [WIDTH-1:0] s1_q;
    reg [WIDTH-1:0] s2_q;
    reg [WIDTH-1:0] s3_q;

    // ----------------------------------------
    // stages and agreement filter
    // ----------------------------------------
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            s1_q       <= {WIDTH{1'b0}};
            s2_q       <= {WIDTH{1'b0}};
            s3_q       <= {WIDTH{1'b0}};
            pin_sync_q <= {WIDTH{1'b0}};
        end
        else if (clk_en)
        begin
            s1_q <= pin_async;
            s2_q <= s1_q;
            s3_q <= s2_q;
            pin_sync_q <= (s2_q & s3_q) | (pin_sync_q & (s2_q ^ s3_q));
        end
    end

endmodule // pps_sync3

// ==== pps_pin_mux.v ====
// Purpose: one selector-driven pin multiplexer
// Assumes: pins already synchronised
// Notes: codes above the top pin give a low level
`timescale 1ns/1ps
`include "pps_defines.vh"

module pps_pin_mux #(
    parameter NUM_PINS = 26
) (
    // selection
    input  wire [NUM_PINS-1:0]     pins,
    input  wire [`PPS_SEL_W-1:0]   sel,
    // result
    output wire                    out_level
);

    // ground code and reserved codes give low
    assign out_level = (sel < NUM_PINS) ? pins[sel] : 1'b0;

endmodule // pps_pin_mux

// ==== pps_input_select.v ====
// Purpose: peripheral input pin select with apb register access
// Assumes: single clock pclk, apb master keeps protocol
// Notes: selected levels are registered
`timescale 1ns/1ps
`include "pps_defines.vh"

// Operation
// - A 5-bit selector code 0 to 25 routes the pin with that index to its input.
// - Code 31 ties the input low and codes 26 to 30 are reserved for software.
// - Every implemented selector bit resets to one so inputs start tied low.
// - Bits outside the selector fields and lock bit 0 read as zero.
// - The timer clock register uses bits 12-8 for timer 5 and bits 4-0 for timer 4.
// - The first capture register uses bits 12-8 for channel 2 and bits 4-0 for channel 1.
// - The second capture register uses bits 4-0 for channel 3, the rest unimplemented.
// - The compare fault register uses bits 4-0 for fault input A.
// - The serial register uses bits 12-8 for clear-to-send and bits 4-0 for receive data.
// - The spi register uses bits 12-8 for the clock input and bits 4-0 for data input.
// - Timer 4 and 5 clock and spi selectors exist only on the larger variant.
// - Selector writes take effect only while the configuration lock bit is zero.
module pps_input_select #(
    parameter NUM_PINS   = `PPS_NUM_PINS,
    parameter LARGE_PART = 1
) (
    // clock, reset, enable
    input  wire                pclk,
    input  wire                presetn,
    input  wire                clk_en,
    // apb slave
    input  wire                psel,
    input  wire                penable,
    input  wire                pwrite,
    input  wire [11:0]         paddr,
    input  wire [31:0]         pwdata,
    output reg  [31:0]         prdata,
    output wire                pready,
    output wire                pslverr,
    // remappable pins
    input  wire [NUM_PINS-1:0] remappable_pin_n,
    // peripheral inputs
    output reg                 timer4_ext_clock,
    output reg                 timer5_ext_clock,
    output reg                 capture_ch1_input,
    output reg                 capture_ch2_input,
    output reg                 capture_ch3_input,
    output reg                 compare_fault_a_input,
    output reg                 serial_rx_input,
    output reg                 serial_cts_input,
    output reg                 spi_clock_input,
    output reg                 spi_data_input
);

    // ----------------------------------------
    // selector storage
    // ----------------------------------------
    // index: 0 t4, 1 t5, 2 ic1, 3 ic2, 4 ic3, 5 fault, 6 rx, 7 cts, 8 spi data, 9 spi clk
    reg  [`PPS_SEL_W-1:0] sel_q [0:`PPS_NUM_SEL-1];
    reg                   pin_config_lock_q;
    wire [NUM_PINS-1:0]   pins_sync;
    wire [`PPS_NUM_SEL-1:0] mux_out;
    wire                  wr_en;
    wire                  sel_wr_ok;
    wire [`PPS_SEL_W-1:0] wlo;
    wire [`PPS_SEL_W-1:0] whi;
    reg  [31:0]           rd_d;
    reg                   addr_ok;

    assign pready  = 1'b1;
    assign pslverr = psel & penable & ~addr_ok;
    assign wr_en   = psel & penable & pwrite & clk_en;
    assign sel_wr_ok = wr_en & ~pin_config_lock_q;
    assign wlo     = pwdata[`PPS_LO_LSB +: `PPS_SEL_W];
    assign whi     = pwdata[`PPS_HI_LSB +: `PPS_SEL_W];

    // ----------------------------------------
    // address decode
    // ----------------------------------------
    always @*
    begin
        case (paddr)
            `PPS_OFF_TMR_CLK: addr_ok = (LARGE_PART != 0);
            `PPS_OFF_CAP_12:  addr_ok = 1'b1;
            `PPS_OFF_CAP_3:   addr_ok = 1'b1;
            `PPS_OFF_CMP_FLT: addr_ok = 1'b1;
            `PPS_OFF_SER:     addr_ok = 1'b1;
            `PPS_OFF_SPI:     addr_ok = (LARGE_PART != 0);
            `PPS_OFF_LOCK:    addr_ok = 1'b1;
            default:          addr_ok = 1'b0;
        endcase
    end

    // ----------------------------------------
    // register writes
    // ----------------------------------------
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sel_q[0] <= `PPS_SEL_RESET;
            sel_q[1] <= `PPS_SEL_RESET;
            sel_q[2] <= `PPS_SEL_RESET;
            sel_q[3] <= `PPS_SEL_RESET;
            sel_q[4] <= `PPS_SEL_RESET;
            sel_q[5] <= `PPS_SEL_RESET;
            sel_q[6] <= `PPS_SEL_RESET;
            sel_q[7] <= `PPS_SEL_RESET;
            sel_q[8] <= `PPS_SEL_RESET;
            sel_q[9] <= `PPS_SEL_RESET;
            pin_config_lock_q <= 1'b0;
        end
        else
        begin
            if (wr_en && paddr == `PPS_OFF_LOCK)
                pin_config_lock_q <= pwdata[0];
            if (sel_wr_ok && LARGE_PART != 0 && paddr == `PPS_OFF_TMR_CLK)
            begin
                sel_q[0] <= wlo;
                sel_q[1] <= whi;
            end
            if (sel_wr_ok && paddr == `PPS_OFF_CAP_12)
            begin
                sel_q[2] <= wlo;
                sel_q[3] <= whi;
            end
            if (sel_wr_ok && paddr == `PPS_OFF_CAP_3)
                sel_q[4] <= wlo;
            if (sel_wr_ok && paddr == `PPS_OFF_CMP_FLT)
                sel_q[5] <= wlo;
            if (sel_wr_ok && paddr == `PPS_OFF_SER)
            begin
                sel_q[6] <= wlo;
                sel_q[7] <= whi;
            end
            if (sel_wr_ok && LARGE_PART != 0 && paddr == `PPS_OFF_SPI)
            begin
                sel_q[8] <= wlo;
                sel_q[9] <= whi;
            end
        end
    end

    // ----------------------------------------
    // read data
    // ----------------------------------------
    always @*
    begin
        rd_d = 32'h0000_0000;
        case (paddr)
            `PPS_OFF_TMR_CLK:
                if (LARGE_PART != 0)
                    rd_d = {19'h0, sel_q[1], 3'h0, sel_q[0]};
            `PPS_OFF_CAP_12:  rd_d = {19'h0, sel_q[3], 3'h0, sel_q[2]};
            `PPS_OFF_CAP_3:   rd_d = {27'h0, sel_q[4]};
            `PPS_OFF_CMP_FLT: rd_d = {27'h0, sel_q[5]};
            `PPS_OFF_SER:     rd_d = {19'h0, sel_q[7], 3'h0, sel_q[6]};
            `PPS_OFF_SPI:
                if (LARGE_PART != 0)
                    rd_d = {19'h0, sel_q[9], 3'h0, sel_q[8]};
            `PPS_OFF_LOCK:    rd_d = {31'h0, pin_config_lock_q};
            default:          rd_d = 32'h0000_0000;
        endcase
    end

    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata <= 32'h0000_0000;
        else if (clk_en && psel && !penable && !pwrite)
            prdata <= rd_d;
    end

    // ----------------------------------------
    // pin synchroniser and multiplexers
    // ----------------------------------------
    pps_sync3 #(
        .WIDTH      (NUM_PINS)
    ) u_sync (
        .pclk       (pclk),
        .presetn    (presetn),
        .clk_en     (clk_en),
        .pin_async  (remappable_pin_n),
        .pin_sync_q (pins_sync)
    );

    genvar gi;
    generate
        for (gi = 0; gi < `PPS_NUM_SEL; gi = gi + 1)
        begin : g_mux
            pps_pin_mux #(
                .NUM_PINS  (NUM_PINS)
            ) u_mux (
                .pins      (pins_sync),
                .sel       (sel_q[gi]),
                .out_level (mux_out[gi])
            );
        end
    endgenerate

    // ----------------------------------------
    // registered peripheral inputs
    // ----------------------------------------
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            timer4_ext_clock      <= 1'b0;
            timer5_ext_clock      <= 1'b0;
            capture_ch1_input     <= 1'b0;
            capture_ch2_input     <= 1'b0;
            capture_ch3_input     <= 1'b0;
            compare_fault_a_input <= 1'b0;
            serial_rx_input       <= 1'b0;
            serial_cts_input      <= 1'b0;
            spi_data_input        <= 1'b0;
            spi_clock_input       <= 1'b0;
        end
        else if (clk_en)
        begin
            timer4_ext_clock      <= mux_out[0] & (LARGE_PART != 0);
            timer5_ext_clock      <= mux_out[1] & (LARGE_PART != 0);
            capture_ch1_input     <= mux_out[2];
            capture_ch2_input     <= mux_out[3];
            capture_ch3_input     <= mux_out[4];
            compare_fault_a_input <= mux_out[5];
            serial_rx_input       <= mux_out[6];
            serial_cts_input      <= mux_out[7];
            spi_data_input        <= mux_out[8] & (LARGE_PART != 0);
            spi_clock_input       <= mux_out[9] & (LARGE_PART != 0);
        end
    end

endmodule // pps_input_select

// ==== pps_input_select_asserts.sv ====
// Purpose: port checks for the input select block
// Assumes: one clock pclk, pins driven as plain levels
// Notes: bound to pps_input_select from the testbench
`timescale 1ns/1ps
`include "pps_defines.vh"

module pps_input_select_asserts #(
    parameter NUM_PINS   = 26,
    parameter LARGE_PART = 1
) (
    // clock, reset, enable
    input wire                pclk,
    input wire                presetn,
    input wire                clk_en,
    // apb
    input wire                psel,
    input wire                penable,
    input wire                pwrite,
    input wire [11:0]         paddr,
    input wire [31:0]         pwdata,
    input wire [31:0]         prdata,
    input wire                pready,
    input wire                pslverr,
    // pins and peripheral inputs
    input wire [NUM_PINS-1:0] remappable_pin_n,
    input wire                timer4_ext_clock,
    input wire                timer5_ext_clock,
    input wire                capture_ch1_input,
    input wire                capture_ch2_input,
    input wire                capture_ch3_input,
    input wire                compare_fault_a_input,
    input wire                serial_rx_input,
    input wire                serial_cts_input,
    input wire                spi_clock_input,
    input wire                spi_data_input
);
    wire [9:0] outs = {spi_clock_input, spi_data_input, serial_cts_input, serial_rx_input,
        compare_fault_a_input, capture_ch3_input, capture_ch2_input, capture_ch1_input,
        timer5_ext_clock, timer4_ext_clock};
    wire       rd_su = psel && !penable && !pwrite && clk_en;
    wire       acc   = psel && penable;
    reg  [3:0] zcnt_q;
    reg  [3:0] qcnt_q;

    // ----------------------------------------
    // quiet-time counters
    // ----------------------------------------
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            zcnt_q <= 4'h0;
            qcnt_q <= 4'h0;
        end
        else
        begin
            zcnt_q <= (remappable_pin_n != 0 || !clk_en) ? 4'h0 : zcnt_q + {3'h0, zcnt_q != 4'hf};
            qcnt_q <= (!$stable(remappable_pin_n) || (acc && pwrite)) ? 4'h0 :
                      qcnt_q + {3'h0, qcnt_q != 4'hf};
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // ----------------------------------------
    // properties
    // ----------------------------------------
    a_unmapped_err: assert property (acc && paddr > `PPS_OFF_LOCK |-> pslverr)
        else $error("unmapped access gave no error");
    a_mapped_ok: assert property (LARGE_PART == 1 && acc && paddr <= `PPS_OFF_LOCK
        && paddr[1:0] == 2'b00 |-> !pslverr) else $error("mapped access gave error");
    a_rd_dual_zero: assert property (rd_su && paddr inside {12'h000, 12'h004, 12'h010,
        12'h014} |=> prdata[31:13] == 0 && prdata[7:5] == 0) else $error("gap bits set");
    a_rd_single_zero: assert property (rd_su && paddr inside {12'h008, 12'h00c}
        |=> prdata[31:5] == 0) else $error("upper bits set");
    a_rd_lock_zero: assert property (rd_su && paddr == `PPS_OFF_LOCK |=> prdata[31:1] == 0)
        else $error("lock word upper bits set");
    a_prdata_hold: assert property (!rd_su |=> $stable(prdata))
        else $error("read data moved without read");
    a_ground_pins: assert property (zcnt_q >= 4'h8 |-> outs == 10'h000)
        else $error("input high with all pins low");
    a_quiet_stable: assert property (qcnt_q >= 4'h8 |-> $stable(outs))
        else $error("input moved with no cause");
endmodule // pps_input_select_asserts

// ==== pps_pin_model.sv ====
// Purpose: far-side driver of the remappable pins
// Assumes: pins are plain logic levels
// Notes: requested pattern lands just after a rising edge
`timescale 1ns/1ps

module pps_pin_model #(
    parameter NUM_PINS = 26
) (
    // clock
    input  wire                pclk,
    // requested levels
    input  wire [NUM_PINS-1:0] pattern,
    // pins
    output reg  [NUM_PINS-1:0] remappable_pin_n
);
    initial remappable_pin_n = {NUM_PINS{1'b0}};
    always @(posedge pclk)
        remappable_pin_n <= pattern;
endmodule // pps_pin_model

// ==== pps_input_select_tb.sv ====
// Purpose: register and routing tests for the input select block
// Assumes: LARGE_PART=1, zero wait apb slave
// Notes: outputs checked after a settle time
`timescale 1ns/1ps
`include "pps_defines.vh"

module pps_input_select_tb;
    reg         pclk    = 1'b0;
    reg         presetn = 1'b0;
    reg         clk_en  = 1'b1;
    reg         psel    = 1'b0;
    reg         penable = 1'b0;
    reg         pwrite  = 1'b0;
    reg  [11:0] paddr   = 12'h000;
    reg  [31:0] pwdata  = 32'h0;
    reg  [25:0] pattern = 26'h3ffffff;
    reg  [49:0] codes   = {5'h05, 5'h16, 5'h13, 5'h11, 5'h0d, 5'h0b, 5'h07, 5'h03, 5'h19, 5'h00};
    wire [31:0] prdata;
    wire        pready;
    wire        pslverr;
    wire [25:0] remappable_pin_n;
    wire        timer4_ext_clock, timer5_ext_clock, capture_ch1_input, capture_ch2_input;
    wire        capture_ch3_input, compare_fault_a_input, serial_rx_input, serial_cts_input;
    wire        spi_clock_input, spi_data_input;
    wire [9:0]  outs = {spi_clock_input, spi_data_input, serial_cts_input, serial_rx_input,
        compare_fault_a_input, capture_ch3_input, capture_ch2_input, capture_ch1_input,
        timer5_ext_clock, timer4_ext_clock};
    integer     n_mismatch = 0;
    integer     n_checks = 0;
    integer     i;
    integer     lo;
    integer     hi;
    reg  [31:0] rd;
    reg         er;

    pps_input_select u_pps_input_select (.*);
    pps_pin_model u_pps_pin_model (.pclk(pclk), .pattern(pattern), .remappable_pin_n(remappable_pin_n));

    initial forever #20 pclk = ~pclk;

    function [4:0] c(input integer k);
        c = codes[k*5 +: 5];
    endfunction

    function [31:0] wd(input [4:0] h, input [4:0] l, input f);
        wd = {{19{f}}, h, {3{f}}, l};
    endfunction

    task chk(input [8*8-1:0] nm, input [31:0] exp, input [31:0] got);
    begin
        n_checks = n_checks + 1;
        if (got !== exp)
        begin
            n_mismatch = n_mismatch + 1;
            $display("[ERR] %0s exp %h got %h", nm, exp, got);
        end
    end
    endtask

    task apb(input w, input [11:0] a, input [31:0] d);
        integer t;
    begin
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        t = 0;
        @(posedge pclk);
        while (pready !== 1'b1 && t < 16)
        begin
            t = t + 1;
            @(posedge pclk);
        end
        rd = prdata;
        er = pslverr;
        if (t >= 16)
            n_mismatch = n_mismatch + 1;
        psel <= 1'b0;
        penable <= 1'b0;
    end
    endtask

    task settle(input [25:0] p);
    begin
        @(posedge pclk);
        pattern <= p;
        repeat (8) @(posedge pclk);
    end
    endtask

    task tally_and_finish;
    begin
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    end
    endtask

    initial
    begin
        #(40 * 20000);
        n_mismatch = n_mismatch + 1;
        tally_and_finish;
    end

    initial
    begin
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        settle(26'h3ffffff);
        chk("gnd", 32'h0, {22'h0, outs});
        for (i = 0; i < 6; i = i + 1)
        begin
            apb(1'b0, i * 4, 32'h0);
            chk("reset", (i == 2 || i == 3) ? 32'h1f : 32'h1f1f, rd);
        end
        apb(1'b0, 12'h01c, 32'h0);
        chk("unmap", 32'h1, {31'h0, er});
        for (i = 0; i < 6; i = i + 1)
        begin
            lo = (i < 2) ? 2 * i : (i < 4) ? i + 2 : 2 * i - 2;
            hi = (i < 2) ? 2 * i + 1 : (i < 4) ? lo : 2 * i - 1;
            apb(1'b1, i * 4, wd(c(hi), c(lo), 1'b1));
            apb(1'b0, i * 4, 32'h0);
            chk("sel", (i == 2 || i == 3) ? {27'h0, c(lo)} : wd(c(hi), c(lo), 1'b0), rd);
        end
        for (i = 0; i < 10; i = i + 1)
        begin
            settle(26'h1 << c(i));
            chk("route", 32'h1 << i, {22'h0, outs});
        end
        apb(1'b1, `PPS_OFF_CMP_FLT, 32'h0);
        settle(26'h1);
        chk("share", 32'h21, {22'h0, outs});
        apb(1'b1, `PPS_OFF_TMR_CLK, wd(5'h1a, 5'h1f, 1'b0));
        settle(26'h3ffffff);
        chk("tied", 32'h3fc, {22'h0, outs});
        apb(1'b1, `PPS_OFF_LOCK, 32'h1);
        apb(1'b1, `PPS_OFF_TMR_CLK, 32'h0);
        apb(1'b0, `PPS_OFF_TMR_CLK, 32'h0);
        chk("locked", 32'h1a1f, rd);
        apb(1'b0, `PPS_OFF_LOCK, 32'h0);
        chk("lockbit", 32'h1, rd);
        apb(1'b1, `PPS_OFF_LOCK, 32'h0);
        apb(1'b1, `PPS_OFF_TMR_CLK, wd(5'h02, 5'h01, 1'b0));
        apb(1'b0, `PPS_OFF_TMR_CLK, 32'h0);
        chk("unlock", 32'h0201, rd);
        clk_en <= 1'b0;
        apb(1'b1, `PPS_OFF_CAP_3, 32'h0);
        clk_en <= 1'b1;
        apb(1'b0, `PPS_OFF_CAP_3, 32'h0);
        chk("frozen", {27'h0, c(4)}, rd);
        tally_and_finish;
    end
endmodule // pps_input_select_tb

bind pps_input_select pps_input_select_asserts #(.NUM_PINS(NUM_PINS), .LARGE_PART(LARGE_PART))
    u_pps_input_select_asserts (.*);
